// File: pgsp_core.sv
`timescale 1ns/1ps
module pgsp_core (
   // Clock and reset
   input  wire logic                         mclk,
   input  wire logic                         sys_rst,
   // Sample stream in
   input  wire logic                         sampleValid,
   input  wire logic signed [pgsp_pkg::SAMPLE_W-1:0] sampleIn,
   // Filter and volume control
   input  wire logic [2:0]                   highpassCornerSelect,
   input  wire logic                         outputPolarityInvert,
   input  wire logic [7:0]                   volumeLevelCode,
   input  wire logic [31:0]                  volumeSlewRate,
   input  wire logic [1:0]                   volumeRampControl,
   input  wire logic [4:0]                   amplifierLevelSetting,
   // Supply control
   input  wire logic                         internalRegulatorMode,
   input  wire logic [1:0]                   outputSupplyMode,
   input  wire logic [1:0]                   supplySwitchDelay,
   input  wire logic [3:0]                   selectorHysteresisTime,
   input  wire logic                         selectorThresholdType,
   input  wire logic [3:0]                   selectorRelativeThreshold,
   input  wire logic [4:0]                   selectorFixedThreshold,
   input  wire logic [1:0]                   selectorIdleThreshold,
   input  wire logic [23:0]                  lowRailLevel,
   input  wire logic                         highRailHeadroomLow,
   // Noise gate control
   input  wire logic [1:0]                   gateThreshold,
   input  wire logic [2:0]                   gateHoldTimer,
   input  wire logic                         gateEnable,
   input  wire logic                         gateRampSelect,
   input  wire logic                         gateFineModeEnable,
   input  wire logic [23:0]                  gateFineLevel,
   input  wire logic [18:3]                  gateFineHysteresis,
   // Output stream and stage control
   output logic                              sampleOutValid,
   output logic signed [pgsp_pkg::SAMPLE_W-1:0] sampleOut,
   output logic [4:0]                        ampLevel,
   output logic                              useHighRail,
   output logic                              stagePowered,
   output logic [15:0]                       currentGain
);
   import pgsp_pkg::*;

   typedef logic signed [SAMPLE_W-1:0] smp_t;

   // ==========================================================
   // Helpers
   function automatic logic [SAMPLE_W-1:0] absVal(input smp_t s);
      return s[SAMPLE_W-1] ? SAMPLE_W'(-s) : SAMPLE_W'(s);
   endfunction

   // Threshold as magnitude: 2^(23 - steps) - 1
   function automatic logic [SAMPLE_W-1:0] dbThresh(input logic [4:0] steps);
      logic [SAMPLE_W-1:0] t;
      t = 24'h7FFFFF;
      return t >> steps;
   endfunction

   // ==========================================================
   // Highpass filter (first order, shift chosen by corner)
   smp_t hpfState_r;
   smp_t hpfOut;
   smp_t hpfDiff;
   logic [3:0] hpfShift;

   always_comb begin
      hpfShift = 4'(13) - {1'b0, highpassCornerSelect};
      hpfDiff  = sampleIn - hpfState_r;
      hpfOut   = (highpassCornerSelect == HPF_BYPASS) ? sampleIn : hpfDiff;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hpfState_r <= '0;
      end else if (sampleValid && highpassCornerSelect != HPF_BYPASS) begin
         hpfState_r <= hpfState_r + (hpfDiff >>> hpfShift);
      end
   end

   // ==========================================================
   // Seven-sample lookahead delay line
   smp_t dly_r [DELAY_LEN];

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         for (int i = 0; i < DELAY_LEN; i++) begin
            dly_r[i] <= '0;
         end
      end else if (sampleValid) begin
         dly_r[0] <= hpfOut;
         for (int i = 1; i < DELAY_LEN; i++) begin
            dly_r[i] <= dly_r[i-1];
         end
      end
   end

   // ==========================================================
   // Volume target gain (iterative half-dB steps)
   logic [7:0]  volCode_r;
   logic [7:0]  calcCnt_r;
   logic [15:0] calcGain_r;
   logic [15:0] targetGain_r;
   logic        calcBusy_r;
   logic [31:0] prodHalf;

   assign prodHalf = calcGain_r * GAIN_HALF_DB;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         volCode_r    <= VOL_RESET;
         targetGain_r <= GAIN_UNITY;
         calcGain_r   <= GAIN_UNITY;
         calcCnt_r    <= '0;
         calcBusy_r   <= 1'b0;
      end else if (!calcBusy_r && volumeLevelCode != volCode_r) begin
         volCode_r  <= volumeLevelCode;
         // First half-dB step is the exact constant, not unity times it
         calcGain_r <= GAIN_HALF_DB;
         calcCnt_r  <= volumeLevelCode - 8'h01;
         calcBusy_r <= (volumeLevelCode <= VOL_MUTE_MAX) && (volumeLevelCode != 8'h00);
         if (volumeLevelCode > VOL_MUTE_MAX) begin
            targetGain_r <= '0;
         end else if (volumeLevelCode == 8'h00) begin
            targetGain_r <= GAIN_UNITY;
         end
      end else if (calcBusy_r) begin
         if (calcCnt_r == 8'h00) begin
            targetGain_r <= calcGain_r;
            calcBusy_r   <= 1'b0;
         end else begin
            calcGain_r <= prodHalf[30:15];
            calcCnt_r  <= calcCnt_r - 8'h01;
         end
      end
   end

   // ==========================================================
   // Noise gate
   logic [SAMPLE_W-1:0] gateLevel;
   logic [SAMPLE_W-1:0] inMag;
   logic [15:0]         gateCnt_r;
   logic [15:0]         gateLimit;
   logic [2:0]          wakeCnt_r;
   logic                gateDown_r;

   assign inMag = absVal(hpfOut);

   always_comb begin
      if (gateFineModeEnable) begin
         gateLevel = gateFineLevel;
         gateLimit = gateFineHysteresis;
      end else begin
         gateLevel = dbThresh(5'd15 + {3'b000, gateThreshold});
         gateLimit = 16'(({13'h0000, gateHoldTimer} + 16'h0001) << GATE_SHIFT);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst || !gateEnable) begin
         gateCnt_r  <= '0;
         gateDown_r <= 1'b0;
         wakeCnt_r  <= '0;
      end else if (sampleValid) begin
         if (inMag >= gateLevel) begin
            gateCnt_r  <= '0;
            gateDown_r <= 1'b0;
            wakeCnt_r  <= 3'(GATE_LEAD);
         end else begin
            if (wakeCnt_r != 3'h0) begin
               wakeCnt_r <= wakeCnt_r - 3'h1;
            end
            if (gateCnt_r >= gateLimit) begin
               gateDown_r <= (wakeCnt_r == 3'h0);
            end else begin
               gateCnt_r <= gateCnt_r + 16'h0001;
            end
         end
      end
   end

   // ==========================================================
   // Volume ramp
   logic [15:0] gainTarget;
   logic [15:0] gain_r;
   logic [31:0] slewAcc_r;
   logic [15:0] stepSize;

   assign gainTarget = (gateDown_r && !gateRampSelect) ? 16'h0000 : targetGain_r;
   assign stepSize   = (volumeSlewRate[31:16] == 16'h0000) ? 16'h0001 : volumeSlewRate[31:16];

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         gain_r    <= GAIN_UNITY;
         slewAcc_r <= '0;
      end else begin
         // Ramp off: gain jumps at once, also with no samples flowing
         if (volumeRampControl == 2'h3) begin
            gain_r <= gainTarget;
         end else if (sampleValid && gain_r < gainTarget) begin
            gain_r <= (gainTarget - gain_r > stepSize) ? gain_r + stepSize : gainTarget;
         end else if (sampleValid && gain_r > gainTarget) begin
            gain_r <= (gain_r - gainTarget > stepSize) ? gain_r - stepSize : gainTarget;
         end
         if (sampleValid) begin
            slewAcc_r <= slewAcc_r + volumeSlewRate;
         end
      end
   end

   // ==========================================================
   // Output gain and polarity
   logic signed [SAMPLE_W+16:0] prodOut;
   smp_t                        scaled;

   assign prodOut = dly_r[GATE_LEAD-1] * $signed({1'b0, gain_r});
   assign scaled  = prodOut[SAMPLE_W+14:15];

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sampleOut      <= '0;
         sampleOutValid <= 1'b0;
         ampLevel       <= '0;
      end else begin
         sampleOutValid <= sampleValid;
         ampLevel       <= amplifierLevelSetting;
         if (sampleValid) begin
            sampleOut <= outputPolarityInvert ? -scaled : scaled;
         end
      end
   end

   // ==========================================================
   // Level-based supply selector
   logic [SAMPLE_W-1:0] selThresh;
   logic [SAMPLE_W-1:0] outMag;
   logic [7:0]          hysCnt_r;
   logic [7:0]          hysLimit;
   logic [3:0]          dlyCnt_r;
   logic                lowSel_r;
   logic                aboveSel;

   assign outMag   = absVal(scaled);
   assign hysLimit = 8'(({4'h0, selectorHysteresisTime} + 8'h01) << HYS_SHIFT);

   always_comb begin
      if (outputSupplyMode == MODE_NEAR_IDLE) begin
         selThresh = dbThresh(5'd20 + {3'b000, selectorIdleThreshold});
      end else if (selectorThresholdType) begin
         selThresh = lowRailLevel - dbThresh(5'd19 - {1'b0, selectorRelativeThreshold});
      end else begin
         selThresh = dbThresh(selectorFixedThreshold);
      end
      aboveSel = outMag >= selThresh;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hysCnt_r <= '0;
         dlyCnt_r <= '0;
         lowSel_r <= 1'b0;
      end else if (sampleValid) begin
         if (aboveSel) begin
            hysCnt_r <= '0;
            if (lowSel_r) begin
               if (dlyCnt_r >= 4'({supplySwitchDelay, 1'b0} >> DLY_SHIFT)) begin
                  lowSel_r <= 1'b0;
                  dlyCnt_r <= '0;
               end else begin
                  dlyCnt_r <= dlyCnt_r + 4'h1;
               end
            end
         end else begin
            dlyCnt_r <= '0;
            if (hysCnt_r >= hysLimit) begin
               lowSel_r <= 1'b1;
            end else begin
               hysCnt_r <= hysCnt_r + 8'h01;
            end
         end
      end
   end

   // ==========================================================
   // Rail choice and stage power
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         useHighRail  <= 1'b1;
         stagePowered <= 1'b1;
         currentGain  <= GAIN_UNITY;
      end else begin
         stagePowered <= !(gateEnable && gateDown_r);
         currentGain  <= gain_r;
         unique case (outputSupplyMode)
            MODE_DUAL:      useHighRail <= highRailHeadroomLow || !lowSel_r;
            MODE_LOW_ONLY:  useHighRail <= 1'b0;
            MODE_HIGH_ONLY: useHighRail <= 1'b1;
            MODE_NEAR_IDLE: useHighRail <= !lowSel_r;
         endcase
      end
   end

   // Regulator mode is a software sequencing duty; not used in logic
   logic unusedReg;
   assign unusedReg = internalRegulatorMode ^ slewAcc_r[0];
endmodule

// File: pgsp_pkg.sv
package pgsp_pkg;
   localparam int          SAMPLE_W       = 24;
   localparam int          GAIN_W         = 16;      // Q1.15 linear gain
   localparam logic [7:0]  VOL_RESET      = 8'h00;
   localparam logic [7:0]  VOL_MUTE_MAX   = 8'hC8;
   localparam logic [15:0] GAIN_UNITY     = 16'h7FFF;
   localparam logic [15:0] GAIN_HALF_DB   = 16'h78D6; // 10^(-0.5/20)
   localparam logic [2:0]  HPF_BYPASS     = 3'h0;
   localparam logic [1:0]  MODE_DUAL      = 2'h0;
   localparam logic [1:0]  MODE_LOW_ONLY  = 2'h1;
   localparam logic [1:0]  MODE_HIGH_ONLY = 2'h2;
   localparam logic [1:0]  MODE_NEAR_IDLE = 2'h3;
   localparam int          GATE_LEAD      = 7;
   localparam int          DELAY_LEN      = 8;
   localparam int          HYS_SHIFT      = 4;  // Log2 of samples per hysteresis step
   localparam int          GATE_SHIFT     = 6;  // Log2 of samples per gate timer step
   localparam int          DLY_SHIFT      = 1;  // Samples per switch delay step
endpackage

// File: pgsp_core_properties.sv
`timescale 1ns/1ps
module pgsp_core_properties (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        sys_rst,
   // Controls
   input wire logic        sampleValid,
   input wire logic [7:0]  volumeLevelCode,
   input wire logic [1:0]  volumeRampControl,
   input wire logic [4:0]  amplifierLevelSetting,
   input wire logic [1:0]  outputSupplyMode,
   input wire logic        highRailHeadroomLow,
   input wire logic        gateEnable,
   // Results
   input wire logic        sampleOutValid,
   input wire logic [4:0]  ampLevel,
   input wire logic        useHighRail,
   input wire logic        stagePowered,
   input wire logic [15:0] currentGain
);
   import pgsp_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ==========
   // Properties
   a_reset_state: assert property (
      $fell(sys_rst) |-> currentGain == GAIN_UNITY && useHighRail && stagePowered && ampLevel == 5'h00)
      else $error("state after reset wrong");
   a_level_copy: assert property (
      !sys_rst |=> ampLevel == $past(amplifierLevelSetting)) else $error("amplifier level not copied");
   a_out_follows: assert property (
      sampleValid |=> sampleOutValid) else $error("output sample missing");
   a_no_spurious: assert property (
      !sampleValid |=> !sampleOutValid) else $error("output sample without input");
   a_mute_gain: assert property (
      (volumeLevelCode > VOL_MUTE_MAX && volumeRampControl == 2'h3) [*8] |-> ##[0:260] currentGain == 16'h0000)
      else $error("mute code left gain open");
   a_unity_gain: assert property (
      (volumeLevelCode == VOL_RESET && volumeRampControl == 2'h3 && !gateEnable) [*8]
      |-> ##[0:260] currentGain == GAIN_UNITY) else $error("code zero not unity");
   a_half_db: assert property (
      (volumeLevelCode == 8'h01 && volumeRampControl == 2'h3 && !gateEnable) [*8]
      |-> ##[0:260] currentGain == GAIN_HALF_DB) else $error("code one not half step");
   a_high_only: assert property (
      (outputSupplyMode == MODE_HIGH_ONLY) [*2] |-> useHighRail) else $error("high-only mode left high rail");
   a_low_only: assert property (
      (outputSupplyMode == MODE_LOW_ONLY) [*2] |-> !useHighRail) else $error("low-only mode used high rail");
   a_headroom_high: assert property (
      (outputSupplyMode == MODE_DUAL && highRailHeadroomLow) [*2] |-> useHighRail)
      else $error("switching with low headroom");
   a_gate_off: assert property (
      (!gateEnable) [*3] |-> stagePowered) else $error("stage down with gate disabled");
endmodule

// File: pgsp_rx_model.sv
`timescale 1ns/1ps
module pgsp_rx_model (
   // Clock
   input  wire logic                         mclk,
   // Sample stream to the core
   output logic                              sampleValid,
   output logic signed [pgsp_pkg::SAMPLE_W-1:0] sampleIn
);
   initial begin
      sampleValid = 1'b0;
      sampleIn    = 24'h000000;
   end
   // One word per frame, data inverted between words
   task automatic send(input logic [23:0] v, input int gap);
      repeat (gap) @(posedge mclk);
      @(posedge mclk);
      sampleValid <= 1'b1;
      sampleIn    <= v;
      @(posedge mclk);
      sampleValid <= 1'b0;
      sampleIn    <= ~v;
   endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
   import pgsp_pkg::*;
   // =======
   // Signals
   logic mclk = 1'b0, sys_rst = 1'b1, outputPolarityInvert = 1'b0, internalRegulatorMode = 1'b1;
   logic selectorThresholdType = 1'b0, highRailHeadroomLow = 1'b0, gateEnable = 1'b0, gateRampSelect = 1'b1;
   logic gateFineModeEnable = 1'b0, sampleValid, sampleOutValid, useHighRail, stagePowered;
   logic [1:0] volumeRampControl = 2'h3, outputSupplyMode = MODE_HIGH_ONLY, supplySwitchDelay = 2'h0;
   logic [1:0] selectorIdleThreshold = 2'h0, gateThreshold = 2'h0, kind = 2'h0;
   logic [2:0] highpassCornerSelect = HPF_BYPASS, gateHoldTimer = 3'h0;
   logic [3:0] selectorHysteresisTime = 4'h0, selectorRelativeThreshold = 4'h0;
   logic [4:0] amplifierLevelSetting = 5'h00, selectorFixedThreshold = 5'h04, ampLevel;
   logic [7:0] volumeLevelCode = VOL_RESET;
   logic [15:0] currentGain;
   logic [18:3] gateFineHysteresis = 16'h0008;
   logic [23:0] lowRailLevel = 24'h100000, gateFineLevel = 24'h000010, hist[$];
   logic [31:0] volumeSlewRate = 32'h0001_0000;
   logic signed [SAMPLE_W-1:0] sampleIn, sampleOut;
   logic [25:0] expQ[$], e;
   int fail_count = 0, num_checks = 0, seed = 58384;
   always #2.5 mclk = ~mclk;
   pgsp_rx_model pgsp_rx_model_i (.mclk, .sampleValid, .sampleIn);
   pgsp_core pgsp_core_i (.mclk, .sys_rst, .sampleValid, .sampleIn, .highpassCornerSelect, .outputPolarityInvert,
      .volumeLevelCode, .volumeSlewRate, .volumeRampControl, .amplifierLevelSetting, .internalRegulatorMode,
      .outputSupplyMode, .supplySwitchDelay, .selectorHysteresisTime, .selectorThresholdType,
      .selectorRelativeThreshold, .selectorFixedThreshold, .selectorIdleThreshold, .lowRailLevel,
      .highRailHeadroomLow, .gateThreshold, .gateHoldTimer, .gateEnable, .gateRampSelect, .gateFineModeEnable,
      .gateFineLevel, .gateFineHysteresis, .sampleOutValid, .sampleOut, .ampLevel, .useHighRail, .stagePowered,
      .currentGain);
   // =====
   // Tasks
   function automatic logic [23:0] loud();
      logic [23:0] v;
      v = $random(seed);
      v[22] = ~v[23];
      return v;
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Output k carries the word taken seven words earlier
   task automatic feed(input logic [23:0] v);
      logic [23:0] old;
      old = 24'h000000;
      hist.push_back(v);
      if (hist.size() > 7) old = hist.pop_front();
      expQ.push_back({kind, 23'h0, old[23] ^ outputPolarityInvert});
      amplifierLevelSetting <= $random(seed);
      lowRailLevel <= $random(seed);
      volumeSlewRate[15:0] <= $random(seed);
      pgsp_rx_model_i.send(v, int'($unsigned($random(seed)) % 2));
   endtask
   task automatic results;
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // =======
   // Monitor
   always @(posedge mclk) begin
      if (sampleOutValid === 1'b1 && expQ.size() > 0) begin
         e = expQ.pop_front();
         if (e[25:24] == 2'h1) `CHK(sampleOut, 24'h000000)
         else if (e[25:24] == 2'h2) `CHK(sampleOut[23], e[0])
      end
   end
   // =========
   // Sequence
   initial begin
      wt(2);
      sys_rst <= 1'b0;
      wt(1); #1;
      `CHK(currentGain, GAIN_UNITY)
      kind = 2'h2;
      for (int i = 0; i < 2; i++) begin
         outputPolarityInvert <= i[0];
         wt(1);
         repeat (12) feed(loud());
      end
      kind = 2'h0;
      for (int c = 0; c < 2; c++) begin
         volumeLevelCode <= c ? 8'hFF : 8'hC9;
         wt(260);
         kind = 2'h1;
         repeat (9) feed(loud());
         kind = 2'h0; #1;
         `CHK(currentGain, 16'h0000)
      end
      volumeLevelCode <= 8'h01;
      wt(260); #1;
      `CHK(currentGain, GAIN_HALF_DB)
      volumeLevelCode <= VOL_RESET;
      wt(260);
      volumeRampControl <= 2'h0;
      volumeLevelCode <= 8'h14;
      repeat (30) feed(24'h000000);
      #1;
      `CHK(currentGain > 16'h7000, 1'b1)
      `CHK(currentGain < GAIN_UNITY, 1'b1)
      volumeRampControl <= 2'h3;
      volumeLevelCode <= VOL_RESET;
      outputSupplyMode <= MODE_LOW_ONLY;
      wt(260); #1;
      `CHK(useHighRail, 1'b0)
      outputSupplyMode <= MODE_DUAL;
      highRailHeadroomLow <= 1'b1;
      wt(3); #1;
      `CHK(useHighRail, 1'b1)
      highRailHeadroomLow <= 1'b0;
      for (int m = 0; m < 2; m++) begin
         outputSupplyMode <= m ? MODE_NEAR_IDLE : MODE_DUAL;
         repeat (60) feed(m ? 24'h000000 : $random(seed) & 24'h0000FF);
         #1;
         `CHK(useHighRail, 1'b0)
         supplySwitchDelay <= $random(seed);
         repeat (12) feed(m ? 24'h000100 : loud());
         #1;
         `CHK(useHighRail, 1'b1)
      end
      outputSupplyMode <= MODE_HIGH_ONLY;
      for (int f = 0; f < 2; f++) begin
         gateEnable <= 1'b1;
         gateFineModeEnable <= f[0];
         gateRampSelect <= ~f[0];
         repeat (80) feed(24'h000000);
         #1;
         `CHK(stagePowered, 1'b0)
         feed(loud());
         feed(24'h000000);
         #1;
         `CHK(stagePowered, 1'b1)
         gateEnable <= 1'b0;
         repeat (80) feed(24'h000000);
         #1;
         `CHK(stagePowered, 1'b1)
      end
      highpassCornerSelect <= 3'h7;
      repeat (200) feed(24'h400000);
      #1;
      `CHK(sampleOut < 24'sh100000, 1'b1)
      highpassCornerSelect <= HPF_BYPASS;
      results();
   end
   initial begin
      #100000;
      fail_count++;
      results();
   end
endmodule
bind pgsp_core pgsp_core_properties pgsp_core_properties_i (.mclk, .sys_rst, .sampleValid, .volumeLevelCode,
   .volumeRampControl, .amplifierLevelSetting, .outputSupplyMode, .highRailHeadroomLow, .gateEnable,
   .sampleOutValid, .ampLevel, .useHighRail, .stagePowered, .currentGain);
